// >>> core/sdfs_pkg.sv
// Package: register map, field positions and carrier types of the SD data status block
// Operation
// - Read-wait request drives card and sets flag; writing one stops it and clears
// - SDIO interrupt seen on line 1 in four-line mode with no transfer active latches until software writes one
// - FIFO overrun, underrun or misaligned store sets sticky failure flag
// - Failed CRC status returned after a sent block sets sticky flag
// - Received block failing CRC sets sticky flag, cleared by writing one
// - Data or busy reception timeout sets sticky flag, cleared by writing one
// - Remaining-data counter reaching zero sets sticky data-finish flag
// - Completed busy-only check sets sticky busy-finish flag
// - Four-line receive mode start bit on line 0 but missing on any of lines 3 to 1 sets sticky error flag
// - Bits 1 and 0 show live transmit and receive progress
// - Transmit mode: space indication while FIFO not full, DMA request if enabled
// - Receive mode: data indication while FIFO not empty, DMA request if enabled
// - Transmit half-level reads one at 32 bytes or fewer
// - Transmit empty reads one exactly at zero bytes
// - Receive last-data reads one once FIFO holds final data of transfer
// - Receive full reads one only at 64 bytes
// - Receive half-level reads one from 32 to 64 bytes
// - Seven-bit field reports bytes held in FIFO
// - Two-bit mode selects idle, busy check, receive, transmit as 00..11
// - Wide-bus setting selects line 0 only or lines 3 to 0
// - DMA-enable setting selects polled or DMA-driven FIFO servicing
package sdfs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_DATA_CTRL   = 32'h5A00002C;
    localparam logic [31:0] ADDR_DATA_STATUS = 32'h5A000034;
    localparam logic [31:0] ADDR_FIFO_STATUS = 32'h5A000038;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_WIDE_BIT  = 16;
    localparam int CTRL_DMA_BIT   = 15;
    localparam int CTRL_MODE_LO   = 12;
    localparam int ST_READ_WAIT   = 10;
    localparam int ST_CARD_IRQ    = 9;
    localparam int ST_FIFO_FAIL   = 8;
    localparam int ST_CRC_STATUS  = 7;
    localparam int ST_RX_CRC      = 6;
    localparam int ST_TIMEOUT     = 5;
    localparam int ST_DATA_FINISH = 4;
    localparam int ST_BUSY_FINISH = 3;
    localparam int ST_START_ERR   = 2;
    localparam int ST_TX_ACTIVE   = 1;
    localparam int ST_RX_ACTIVE   = 0;
    localparam int FS_TX_SPACE    = 13;
    localparam int FS_RX_DATA     = 12;
    localparam int FS_TX_HALF     = 11;
    localparam int FS_TX_EMPTY    = 10;
    localparam int FS_RX_LAST     = 9;
    localparam int FS_RX_FULL     = 8;
    localparam int FS_RX_HALF     = 7;

    // ------------------------------------------------------------------
    // Reset values and levels
    // ------------------------------------------------------------------
    localparam logic [8:0]  FLAGS_RESET   = 9'h000;
    localparam logic [16:0] CTRL_RESET    = 17'h00000;
    localparam logic [6:0]  FIFO_DEPTH    = 7'h40;
    localparam logic [6:0]  HALF_LEVEL    = 7'h20;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SDFS_MODE_IDLE = 2'b00,
        SDFS_MODE_BUSY = 2'b01,
        SDFS_MODE_RX   = 2'b10,
        SDFS_MODE_TX   = 2'b11
    } sdfs_mode_t;

    typedef struct packed {
        logic read_wait_issue;
        logic fifo_misalign;
        logic crc_status_bad;
        logic rx_crc_bad;
        logic data_timeout;
        logic remain_zero;
        logic busy_done;
        logic block_end;
        logic tx_active;
        logic rx_active;
        logic rx_last;
        logic fifo_push;
        logic fifo_pop;
    } sdfs_engine_t;

    typedef struct packed {
        sdfs_mode_t mode;
        logic       four_line_select;
        logic       dma_service_enable;
    } sdfs_ctrl_t;

endpackage

// >>> core/sdfs_status.sv
// SD host data-path and FIFO status registers with DMA request and link sampling
`timescale 1ns/1ps
`default_nettype none
module sdfs_status #(
    parameter int ADDR_W = 32
) (
    input  wire logic                  clk,             // Peripheral bus clock
    input  wire logic                  rst_n,           // Synchronous reset, active low
    input  wire logic                  ce,              // Clock enable, freezes state when low
    input  wire logic [ADDR_W-1:0]     addr,            // Register address
    input  wire logic [31:0]           wdata,           // Write data
    input  wire logic                  wr,              // Write strobe
    input  wire logic                  rd,              // Read strobe
    output logic      [31:0]           rdata,           // Read data, cycle after rd
    input  wire sdfs_pkg::sdfs_engine_t eng,            // Events and levels from data engine
    input  wire logic                  link_clk,        // Card link clock, sampled
    input  wire logic [3:0]            link_dat,        // Card data lines, sampled
    output sdfs_pkg::sdfs_ctrl_t       ctrl,            // Transfer settings to engine
    output logic                       read_wait_drive, // Read-wait request toward card
    output logic                       dma_req          // DMA transfer request
);

    // ------------------------------------------------------------------
    // Link synchronisers
    // ------------------------------------------------------------------
    logic [4:0] link_s1_r;
    logic [4:0] link_s2_r;
    logic       link_clk_d_r;
    logic       link_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Idle levels: link clock low, pulled-up data lines high, so no false edge
            link_s1_r <= 5'h0F;
            link_s2_r <= 5'h0F;
        end else if (ce) begin
            link_s1_r <= {link_clk, link_dat};
            link_s2_r <= link_s1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_clk_d_r <= 1'b0;
        end else if (ce) begin
            link_clk_d_r <= link_s2_r[4];
        end
    end

    assign link_rise = link_s2_r[4] && !link_clk_d_r;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [16:0] ctrl_r;
    logic        wr_ctrl;
    logic        wr_stat;

    assign wr_ctrl = wr && (addr == ADDR_W'(sdfs_pkg::ADDR_DATA_CTRL));
    assign wr_stat = wr && (addr == ADDR_W'(sdfs_pkg::ADDR_DATA_STATUS));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= sdfs_pkg::CTRL_RESET;
        end else if (ce && wr_ctrl) begin
            ctrl_r <= wdata[16:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= '{mode: sdfs_pkg::SDFS_MODE_IDLE, four_line_select: 1'b0,
                      dma_service_enable: 1'b0};
        end else if (ce) begin
            ctrl.mode               <= sdfs_pkg::sdfs_mode_t'(
                ctrl_r[sdfs_pkg::CTRL_MODE_LO +: 2]);
            ctrl.four_line_select   <= ctrl_r[sdfs_pkg::CTRL_WIDE_BIT];
            ctrl.dma_service_enable <= ctrl_r[sdfs_pkg::CTRL_DMA_BIT];
        end
    end

    sdfs_pkg::sdfs_mode_t mode;
    logic                 wide;
    logic                 dma_en;

    assign mode   = sdfs_pkg::sdfs_mode_t'(ctrl_r[sdfs_pkg::CTRL_MODE_LO +: 2]);
    assign wide   = ctrl_r[sdfs_pkg::CTRL_WIDE_BIT];
    assign dma_en = ctrl_r[sdfs_pkg::CTRL_DMA_BIT];

    // ------------------------------------------------------------------
    // FIFO byte count
    // ------------------------------------------------------------------
    logic [6:0] count_r;
    logic [6:0] count_nxt;
    logic       overrun;
    logic       underrun;

    always_comb begin
        overrun   = 1'b0;
        underrun  = 1'b0;
        count_nxt = count_r;
        if (eng.fifo_push && !eng.fifo_pop) begin
            if (count_r == sdfs_pkg::FIFO_DEPTH) begin
                overrun = 1'b1;
            end else begin
                count_nxt = count_r + 7'h01;
            end
        end else if (eng.fifo_pop && !eng.fifo_push) begin
            if (count_r == 7'h00) begin
                underrun = 1'b1;
            end else begin
                count_nxt = count_r - 7'h01;
            end
        end else if (eng.fifo_pop && eng.fifo_push && count_r == 7'h00) begin
            underrun = 1'b1;
            count_nxt = 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= 7'h00;
        end else if (ce) begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Card-side detectors
    // ------------------------------------------------------------------
    logic       await_start_r;
    logic       remain_zero_d_r;
    logic       start_seen;
    logic       start_bad;
    logic       card_irq;
    logic [3:0] lines;

    assign lines      = link_s2_r[3:0];
    assign start_seen = link_rise && !lines[0];
    assign start_bad  = start_seen && wide && (lines != 4'h0);
    assign card_irq   = link_rise && wide && !lines[1]
                        && !eng.rx_active && !eng.tx_active;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            await_start_r <= 1'b0;
        end else if (ce) begin
            if (mode != sdfs_pkg::SDFS_MODE_RX) begin
                await_start_r <= 1'b0;
            end else if (eng.block_end || !eng.rx_active) begin
                await_start_r <= 1'b1;
            end else if (start_seen) begin
                await_start_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remain_zero_d_r <= 1'b0;
        end else if (ce) begin
            remain_zero_d_r <= eng.remain_zero;
        end
    end

    // ------------------------------------------------------------------
    // Sticky flags, set wins over write-one clear
    // ------------------------------------------------------------------
    logic [8:0] flags_r;
    logic [8:0] flag_set;
    logic [8:0] flag_clr;

    always_comb begin
        flag_set = 9'h000;
        flag_set[sdfs_pkg::ST_READ_WAIT - 2]   = eng.read_wait_issue;
        flag_set[sdfs_pkg::ST_CARD_IRQ - 2]    = card_irq;
        flag_set[sdfs_pkg::ST_FIFO_FAIL - 2]   = overrun || underrun
                                                 || eng.fifo_misalign;
        flag_set[sdfs_pkg::ST_CRC_STATUS - 2]  = eng.crc_status_bad;
        flag_set[sdfs_pkg::ST_RX_CRC - 2]      = eng.rx_crc_bad;
        flag_set[sdfs_pkg::ST_TIMEOUT - 2]     = eng.data_timeout;
        flag_set[sdfs_pkg::ST_DATA_FINISH - 2] = eng.remain_zero
                                                 && !remain_zero_d_r;
        flag_set[sdfs_pkg::ST_BUSY_FINISH - 2] = eng.busy_done
            && (mode == sdfs_pkg::SDFS_MODE_BUSY);
        flag_set[sdfs_pkg::ST_START_ERR - 2]   = await_start_r && start_bad;
    end

    assign flag_clr = wr_stat ? wdata[10:2] : 9'h000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_r <= sdfs_pkg::FLAGS_RESET;
        end else if (ce) begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_wait_drive <= 1'b0;
        end else if (ce) begin
            read_wait_drive <= flags_r[sdfs_pkg::ST_READ_WAIT - 2] && !flag_clr[8]
                               || eng.read_wait_issue;
        end
    end

    // ------------------------------------------------------------------
    // Live progress and FIFO levels
    // ------------------------------------------------------------------
    logic [1:0] progress_r;
    logic       rx_last_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            progress_r <= 2'b00;
            rx_last_r  <= 1'b0;
        end else if (ce) begin
            progress_r <= {eng.tx_active, eng.rx_active};
            rx_last_r  <= eng.rx_last && (mode == sdfs_pkg::SDFS_MODE_RX);
        end
    end

    function automatic logic [6:0] fifo_levels(input logic [6:0] cnt,
                                               input sdfs_pkg::sdfs_mode_t m);
        logic [6:0] lv;
        lv    = 7'h00;
        lv[6] = (m == sdfs_pkg::SDFS_MODE_TX) && (cnt < sdfs_pkg::FIFO_DEPTH);
        lv[5] = (m == sdfs_pkg::SDFS_MODE_RX) && (cnt != 7'h00);
        // Level bits of one direction read zero outside that direction's mode
        lv[4] = (m == sdfs_pkg::SDFS_MODE_TX) && (cnt <= sdfs_pkg::HALF_LEVEL);
        lv[3] = (m == sdfs_pkg::SDFS_MODE_TX) && (cnt == 7'h00);
        lv[1] = (m == sdfs_pkg::SDFS_MODE_RX) && (cnt == sdfs_pkg::FIFO_DEPTH);
        lv[0] = (m == sdfs_pkg::SDFS_MODE_RX) && (cnt >= sdfs_pkg::HALF_LEVEL);
        return lv;
    endfunction

    logic [6:0] lv_now;
    logic [6:0] lv_nxt;

    assign lv_now = fifo_levels(count_r, mode);
    assign lv_nxt = fifo_levels(count_nxt, mode);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dma_req <= 1'b0;
        end else if (ce) begin
            dma_req <= dma_en && (lv_nxt[6] || lv_nxt[5]);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h00000000;
        if (addr == ADDR_W'(sdfs_pkg::ADDR_DATA_CTRL)) begin
            rd_val[16:0] = ctrl_r;
        end else if (addr == ADDR_W'(sdfs_pkg::ADDR_DATA_STATUS)) begin
            rd_val[10:0] = {flags_r, progress_r};
        end else if (addr == ADDR_W'(sdfs_pkg::ADDR_FIFO_STATUS)) begin
            rd_val[sdfs_pkg::FS_TX_SPACE] = lv_now[6];
            rd_val[sdfs_pkg::FS_RX_DATA]  = lv_now[5];
            rd_val[sdfs_pkg::FS_TX_HALF]  = lv_now[4];
            rd_val[sdfs_pkg::FS_TX_EMPTY] = lv_now[3];
            rd_val[sdfs_pkg::FS_RX_LAST]  = rx_last_r;
            rd_val[sdfs_pkg::FS_RX_FULL]  = lv_now[1];
            rd_val[sdfs_pkg::FS_RX_HALF]  = lv_now[0];
            rd_val[6:0]                   = count_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            rdata <= rd ? rd_val : 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// >>> verif/sdfs_card_model.sv
// Card-side model: link clock and data lines during frames
`timescale 1ns/1ps
`default_nettype none
module sdfs_card_model (
    input  wire logic       frame_en, // Frame in progress
    input  wire logic [3:0] pattern,  // Levels the card puts on the data lines
    output logic            link_clk, // Link clock, still outside frames
    output logic      [3:0] link_dat  // Data lines
);
    // Odd start offset keeps link edges away from bus clock edges
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever begin
            #40;
            link_clk = frame_en ? ~link_clk : 1'b0;
        end
    end
    // Lines have pull-ups, so a released line reads high
    assign link_dat = frame_en ? pattern : 4'hF;
endmodule
`default_nettype wire

// >>> verif/sdfs_status_assertions.sv
// Checker: port-level properties of the SD data status block
`timescale 1ns/1ps
`default_nettype none
module sdfs_status_assertions #(
    parameter int ADDR_W = 32
) (
    input wire logic                   clk,             // Clock
    input wire logic                   rst_n,           // Reset, active low
    input wire logic                   ce,              // Clock enable
    input wire logic [ADDR_W-1:0]      addr,            // Address
    input wire logic [31:0]            wdata,           // Write data
    input wire logic                   wr,              // Write strobe
    input wire logic                   rd,              // Read strobe
    input wire logic [31:0]            rdata,           // Read data
    input wire sdfs_pkg::sdfs_engine_t eng,             // Engine events
    input wire logic                   link_clk,        // Link clock
    input wire logic [3:0]             link_dat,        // Link data
    input wire sdfs_pkg::sdfs_ctrl_t   ctrl,            // Settings
    input wire logic                   read_wait_drive, // Read-wait request
    input wire logic                   dma_req          // DMA request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic st_rd;
    logic st_wr;
    assign st_rd = rd && addr == sdfs_pkg::ADDR_DATA_STATUS;
    assign st_wr = wr && addr == sdfs_pkg::ADDR_DATA_STATUS;

    property p_rw_set;
        ce && eng.read_wait_issue |-> ##[1:2] read_wait_drive;
    endproperty
    a_rw_set: assert property (p_rw_set) else $error("read wait not driven");
    property p_rw_hold;
        read_wait_drive && !(st_wr && wdata[10]) |=> read_wait_drive;
    endproperty
    a_rw_hold: assert property (p_rw_hold) else $error("read wait dropped");
    property p_rw_clr;
        ce && st_wr && wdata[10] && !eng.read_wait_issue |-> ##[1:2] !read_wait_drive;
    endproperty
    a_rw_clr: assert property (p_rw_clr) else $error("read wait not released");
    property p_timeout;
        ce && eng.data_timeout ##1 !st_wr ##1 st_rd |=> rdata[5];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not set");
    property p_reserved;
        st_rd |=> rdata[31:11] == 21'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("status upper bits set");
    property p_live_tx;
        eng.tx_active ##1 st_rd |=> rdata[1];
    endproperty
    a_live_tx: assert property (p_live_tx) else $error("tx progress bit low");
    property p_fifo_fields;
        $past(rd) && $past(addr) == sdfs_pkg::ADDR_FIFO_STATUS |->
            rdata[6:0] <= 7'h40 && rdata[31:14] == 18'h0
            && (!rdata[8] || rdata[6:0] == 7'h40) && (!rdata[10] || rdata[6:0] == 7'h00)
            && (!rdata[7] || rdata[6:0] >= 7'h20) && (!rdata[11] || rdata[6:0] <= 7'h20);
    endproperty
    a_fifo_fields: assert property (p_fifo_fields) else $error("fifo level bits wrong");
    property p_dma_off;
        !ctrl.dma_service_enable && $past(!ctrl.dma_service_enable) |-> !dma_req;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("dma request while disabled");
endmodule
bind sdfs_status sdfs_status_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .eng(eng), .link_clk(link_clk), .link_dat(link_dat), .ctrl(ctrl),
    .read_wait_drive(read_wait_drive), .dma_req(dma_req));
`default_nettype wire

// >>> verif/tb_top.sv
// Testbench: register-level checks of the SD data status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] ST = sdfs_pkg::ADDR_DATA_STATUS;
    localparam logic [31:0] FS = sdfs_pkg::ADDR_FIFO_STATUS;
    localparam logic [31:0] CT = sdfs_pkg::ADDR_DATA_CTRL;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [31:0]            addr = '0, wdata = '0, rdata;
    logic                   wr = 1'b0, rd = 1'b0, rw_drive, dma_req, frame_en = 1'b0, link_clk;
    logic [3:0]             pat = 4'hF, link_dat;
    sdfs_pkg::sdfs_engine_t eng = '0, lv = '0, e;
    sdfs_pkg::sdfs_ctrl_t   ctrl;
    int                     error_cnt = 0, total_checks = 0, i, n;
    int                     ebit[5] = '{12, 11, 10, 9, 8};
    int                     sbit[5] = '{10, 8, 7, 6, 5};

    always #2 clk = ~clk;

    sdfs_status DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .eng(eng), .link_clk(link_clk), .link_dat(link_dat),
        .ctrl(ctrl), .read_wait_drive(rw_drive), .dma_req(dma_req));
    sdfs_card_model CARD (.frame_en(frame_en), .pattern(pat), .link_clk(link_clk),
        .link_dat(link_dat));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] ex);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, ex, rdata);
    endtask
    task automatic pulse(input sdfs_pkg::sdfs_engine_t p);
        @(posedge clk);
        eng <= lv | p;
        @(posedge clk);
        eng <= lv;
    endtask
    task automatic frame(input logic [3:0] p);
        @(posedge clk);
        pat <= p;
        frame_en <= 1'b1;
        repeat (100) @(posedge clk);
        frame_en <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    function automatic logic [31:0] fexp(input int c, input logic tx, input logic last);
        fexp = 32'(c);
        if (tx) begin
            fexp[13] = c < 64;
            fexp[11] = c <= 32;
            fexp[10] = c == 0;
        end else begin
            fexp[12] = c > 0;
            fexp[9] = last;
            fexp[8] = c == 64;
            fexp[7] = c >= 32;
        end
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("status_reset", ST, 32'h0);
        rd_chk("fifo_reset", FS, 32'h0);
        rd_chk("unmapped", 32'h5A000044, 32'h0);
        for (i = 0; i < 5; i++) begin
            e = '0;
            e[ebit[i]] = 1'b1;
            pulse(e);
            rd_chk("flag_set", ST, 32'h1 << sbit[i]);
            chk("rw_drive", 32'(sbit[i] == 10), 32'(rw_drive));
            wr_reg(ST, ~(32'h1 << sbit[i]));
            rd_chk("flag_keep", ST, 32'h1 << sbit[i]);
            wr_reg(ST, 32'h1 << sbit[i]);
            rd_chk("flag_clr", ST, 32'h0);
            chk("rw_release", 32'h0, 32'(rw_drive));
        end
        lv.remain_zero = 1'b1;
        pulse('0);
        rd_chk("data_finish", ST, 32'h10);
        wr_reg(ST, 32'h10);
        rd_chk("finish_clr", ST, 32'h0);
        lv.remain_zero = 1'b0;
        wr_reg(CT, 32'h1000);
        e = '0;
        e.busy_done = 1'b1;
        pulse(e);
        rd_chk("busy_finish", ST, 32'h8);
        wr_reg(ST, 32'h8);
        lv.tx_active = 1'b1;
        lv.rx_active = 1'b1;
        pulse('0);
        wr_reg(ST, 32'h3);
        rd_chk("live_on", ST, 32'h3);
        lv.tx_active = 1'b0;
        lv.rx_active = 1'b0;
        pulse('0);
        rd_chk("live_off", ST, 32'h0);
        wr_reg(CT, 32'hB000);
        rd_chk("tx_empty", FS, fexp(0, 1'b1, 1'b0));
        chk("ctrl_tx_dma", 32'hD, 32'(ctrl));
        rd_chk("ctrl_rb", CT, 32'hB000);
        e = '0;
        e.fifo_push = 1'b1;
        for (n = 1; n <= 64; n++) begin
            pulse(e);
            rd_chk("tx_level", FS, fexp(n, 1'b1, 1'b0));
            chk("tx_dma", 32'(n < 64), 32'(dma_req));
        end
        pulse(e);
        rd_chk("overrun", ST, 32'h100);
        rd_chk("overrun_cnt", FS, fexp(64, 1'b1, 1'b0));
        wr_reg(ST, 32'h100);
        wr_reg(CT, 32'hA000);
        lv.rx_last = 1'b1;
        pulse('0);
        rd_chk("rx_full", FS, fexp(64, 1'b0, 1'b1));
        e = '0;
        e.fifo_pop = 1'b1;
        for (n = 63; n >= 0; n--) begin
            pulse(e);
            rd_chk("rx_level", FS, fexp(n, 1'b0, 1'b1));
            chk("rx_dma", 32'(n > 0), 32'(dma_req));
        end
        pulse(e);
        rd_chk("underrun", ST, 32'h100);
        wr_reg(ST, 32'h100);
        lv.rx_last = 1'b0;
        wr_reg(CT, 32'h2000);
        e = '0;
        e.fifo_push = 1'b1;
        pulse(e);
        chk("dma_disabled", 32'h0, 32'(dma_req));
        rd_chk("polled_level", FS, fexp(1, 1'b0, 1'b0));
        wr_reg(CT, 32'h10000);
        frame(4'b1101);
        rd_chk("card_irq", ST, 32'h200);
        chk("ctrl_wide", 32'h2, 32'(ctrl));
        wr_reg(ST, 32'h200);
        wr_reg(CT, 32'h12000);
        frame(4'b1110);
        rd_chk("start_err", ST, 32'h4);
        wr_reg(ST, 32'h4);
        wr_reg(CT, 32'h2000);
        frame(4'b1110);
        rd_chk("single_line", ST, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
